// ### pkg/lqta_defs.svh
// offsets, field positions, reset values and codes of the link quality threshold access block
`ifndef LQTA_DEFS_SVH
`define LQTA_DEFS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define LQTA_IDX_DATA 8'h1E
`define LQTA_IDX_WARN 8'h20
`define LQTA_IDX_CTRL 8'h21

// ----------------------------------------------------------------------------
// data register fields
// ----------------------------------------------------------------------------
`define LQTA_BIT_SAMPLE 13
`define LQTA_BIT_STROBE 12
`define LQTA_PSEL_HI 11
`define LQTA_PSEL_LO 9
`define LQTA_BIT_BSEL 8
`define LQTA_BYTE_HI 7
`define LQTA_BYTE_LO 0

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define LQTA_BIT_PWR_DOWN 0

// ----------------------------------------------------------------------------
// parameter select codes
// ----------------------------------------------------------------------------
`define LQTA_PSEL_C1 3'h0
`define LQTA_PSEL_GAIN 3'h1
`define LQTA_PSEL_BLW 3'h2
`define LQTA_PSEL_FOFF 3'h3
`define LQTA_PSEL_FCTL 3'h4
`define LQTA_PSEL_VAR 3'h5
`define LQTA_NUM_PAIRS 5

// ----------------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------------
`define LQTA_THR_RST 8'h80
`define LQTA_VAR_THR_RST 16'h8080
`define LQTA_WARN_W 11
`define LQTA_WARN_VAR 10
`define LQTA_RD_UNMAPPED 32'h0000_0000

`endif

// ### pkg/lqta_pkg.sv
// types of the link quality threshold access block
package lqta_pkg;

	typedef logic [2:0] lqta_psel_t;
	typedef logic [7:0] lqta_byte_t;

	// one threshold pair with its comparison result
	typedef struct packed {
		lqta_byte_t low;
		lqta_byte_t high;
		logic lo_hit;
		logic hi_hit;
	} lqta_pair_s;

	// state of the register bank apart from the five threshold pairs
	typedef struct packed {
		logic sample;
		lqta_psel_t psel;
		logic bsel;
		lqta_byte_t captured;
		logic pwr_down;
		logic [10:0] warn;
		logic [15:0] var_thr;
		logic var_hit;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} lqta_top_s;

endpackage

// ### logic/lqta_thr_pair.sv
// one low/high threshold pair with its crossing detectors
`include "lqta_defs.svh"

module lqta_thr_pair (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_wr,
	input wire logic i_bound,
	input wire logic [7:0] i_byte,
	input wire logic [7:0] i_live,
	output logic [7:0] o_low,
	output logic [7:0] o_high,
	output logic o_lo_hit,
	output logic o_hi_hit
);

	lqta_pkg::lqta_pair_s q;
	lqta_pkg::lqta_pair_s d;

	always_comb begin
		d = q;
		if (i_wr && !i_bound) begin
			d.low = i_byte;
		end
		if (i_wr && i_bound) begin
			d.high = i_byte;
		end
		// live value below low or above high bound
		d.lo_hit = i_live < q.low;
		d.hi_hit = i_live > q.high;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			q.low <= `LQTA_THR_RST;
			q.high <= `LQTA_THR_RST;
			q.lo_hit <= 1'b0;
			q.hi_hit <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign o_low = q.low;
	assign o_high = q.high;
	assign o_lo_hit = q.lo_hit;
	assign o_hi_hit = q.hi_hit;

endmodule // lqta_thr_pair

// ### logic/lqta_top.sv
// apb register bank for link quality thresholds and parameter sampling
`include "lqta_defs.svh"

module lqta_top (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [7:0] i_live_c1,
	input wire logic [7:0] i_live_gain,
	input wire logic [7:0] i_live_blw,
	input wire logic [7:0] i_live_foff,
	input wire logic [7:0] i_live_fctl,
	input wire logic [31:0] i_variance,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [10:0] o_warn
);

	// ------------------------------------------------------------------------
	// state and nets
	// ------------------------------------------------------------------------
	lqta_pkg::lqta_top_s q;
	lqta_pkg::lqta_top_s d;

	logic [7:0] live [`LQTA_NUM_PAIRS];
	logic [7:0] thr_low [`LQTA_NUM_PAIRS];
	logic [7:0] thr_high [`LQTA_NUM_PAIRS];
	logic [`LQTA_NUM_PAIRS-1:0] lo_hit;
	logic [`LQTA_NUM_PAIRS-1:0] hi_hit;
	logic [`LQTA_NUM_PAIRS-1:0] pair_wr;

	logic access;
	logic done;
	logic sel_data;
	logic sel_warn;
	logic sel_ctrl;
	logic mapped;
	logic wr_data;
	logic thr_write;
	logic [2:0] wr_psel;
	logic wr_bsel;
	logic [7:0] wr_byte;
	logic [7:0] thr_rd;
	logic [7:0] live_new;
	logic [7:0] data_byte;
	logic [31:0] rdata;
	logic [10:0] warn_set;
	logic [10:0] warn_clr;

	assign live[0] = i_live_c1;
	assign live[1] = i_live_gain;
	assign live[2] = i_live_blw;
	assign live[3] = i_live_foff;
	assign live[4] = i_live_fctl;

	// ------------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------------
	assign sel_data = i_paddr == {2'b00, `LQTA_IDX_DATA, 2'b00};
	assign sel_warn = i_paddr == {2'b00, `LQTA_IDX_WARN, 2'b00};
	assign sel_ctrl = i_paddr == {2'b00, `LQTA_IDX_CTRL, 2'b00};
	assign mapped = sel_data | sel_warn | sel_ctrl;

	// one wait state: pready rises in the second access cycle
	assign access = i_psel & i_penable;
	assign done = access & q.pready;
	assign wr_data = done & i_pwrite & sel_data;

	// ------------------------------------------------------------------------
	// fields of the write word
	// ------------------------------------------------------------------------
	assign wr_psel = i_pwdata[`LQTA_PSEL_HI:`LQTA_PSEL_LO];
	assign wr_bsel = i_pwdata[`LQTA_BIT_BSEL];
	assign wr_byte = i_pwdata[`LQTA_BYTE_HI:`LQTA_BYTE_LO];

	// strobe only counts with sampling off and the device powered up
	assign thr_write = wr_data & i_pwdata[`LQTA_BIT_STROBE]
		& ~i_pwdata[`LQTA_BIT_SAMPLE]
		& ~q.pwr_down;

	// ------------------------------------------------------------------------
	// threshold pairs
	// ------------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `LQTA_NUM_PAIRS; gi++) begin : g_pair
			assign pair_wr[gi] = thr_write & (wr_psel == 3'(gi));
			lqta_thr_pair u_pair (
				.i_clk(i_clk),
				.i_rstn(i_rstn),
				.i_wr(pair_wr[gi]),
				.i_bound(wr_bsel),
				.i_byte(wr_byte),
				.i_live(live[gi]),
				.o_low(thr_low[gi]),
				.o_high(thr_high[gi]),
				.o_lo_hit(lo_hit[gi]),
				.o_hi_hit(hi_hit[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------------------
	// selection of threshold and live value
	// ------------------------------------------------------------------------
	always_comb begin
		thr_rd = 8'h00;
		if (q.psel < `LQTA_PSEL_VAR) begin
			thr_rd = q.bsel ? thr_high[q.psel] : thr_low[q.psel];
		end else if (q.psel == `LQTA_PSEL_VAR) begin
			thr_rd = q.bsel ? q.var_thr[15:8] : q.var_thr[7:0];
		end
	end

	// live value chosen by the select fields of the current write
	always_comb begin
		live_new = 8'h00;
		if (wr_psel < `LQTA_PSEL_VAR) begin
			live_new = live[wr_psel];
		end else if (wr_psel == `LQTA_PSEL_VAR) begin
			live_new = wr_bsel ? i_variance[31:24] : i_variance[23:16];
		end
	end

	// ------------------------------------------------------------------------
	// read data
	// ------------------------------------------------------------------------
	assign data_byte = q.sample ? q.captured : thr_rd;

	always_comb begin
		rdata = `LQTA_RD_UNMAPPED;
		if (sel_data) begin
			rdata[`LQTA_BIT_SAMPLE] = q.sample;
			rdata[`LQTA_PSEL_HI:`LQTA_PSEL_LO] = q.psel;
			rdata[`LQTA_BIT_BSEL] = q.bsel;
			rdata[`LQTA_BYTE_HI:`LQTA_BYTE_LO] = data_byte;
			// bits 15:14 and the strobe stay zero
			rdata[15:14] = 2'b00;
			rdata[`LQTA_BIT_STROBE] = 1'b0;
		end else if (sel_warn) begin
			rdata[10:0] = q.warn;
		end else if (sel_ctrl) begin
			rdata[`LQTA_BIT_PWR_DOWN] = q.pwr_down;
		end
	end

	// ------------------------------------------------------------------------
	// warning flags
	// ------------------------------------------------------------------------
	// bit 2i low crossing, bit 2i+1 high crossing, bit 10 variance high
	always_comb begin
		warn_set = 11'h000;
		for (int i = 0; i < `LQTA_NUM_PAIRS; i++) begin
			warn_set[2*i] = lo_hit[i];
			warn_set[2*i+1] = hi_hit[i];
		end
		warn_set[`LQTA_WARN_VAR] = q.var_hit;
	end

	// only the bits returned by this read are cleared
	assign warn_clr = (done & ~i_pwrite & sel_warn) ? q.prdata[10:0] : 11'h000;

	// ------------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------------
	always_comb begin
		d = q;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		if (access && !q.pready) begin
			d.pready = 1'b1;
			d.prdata = i_pwrite ? 32'h0000_0000 : rdata;
			d.pslverr = ~mapped;
		end
		if (wr_data) begin
			// bits 15:14 and the strobe are not stored
			d.sample = i_pwdata[`LQTA_BIT_SAMPLE];
			d.psel = wr_psel;
			d.bsel = wr_bsel;
			if (i_pwdata[`LQTA_BIT_SAMPLE]) begin
				d.captured = live_new;
			end
			if (thr_write && wr_psel == `LQTA_PSEL_VAR) begin
				if (wr_bsel) begin
					d.var_thr[15:8] = wr_byte;
				end else begin
					d.var_thr[7:0] = wr_byte;
				end
			end
		end
		if (done && i_pwrite && sel_ctrl) begin
			d.pwr_down = i_pwdata[`LQTA_BIT_PWR_DOWN];
		end
		d.var_hit = i_variance[31:16] > q.var_thr;
		// a crossing in the clearing cycle survives
		d.warn = (q.warn & ~warn_clr) | warn_set;
	end

	// ------------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			q.sample <= 1'b0;
			q.psel <= `LQTA_PSEL_C1;
			q.bsel <= 1'b0;
			q.captured <= `LQTA_THR_RST;
			q.pwr_down <= 1'b0;
			q.warn <= 11'h000;
			q.var_thr <= `LQTA_VAR_THR_RST;
			q.var_hit <= 1'b0;
			q.pready <= 1'b0;
			q.pslverr <= 1'b0;
			q.prdata <= 32'h0000_0000;
		end else begin
			q <= d;
		end
	end

	assign o_prdata = q.prdata;
	assign o_pready = q.pready;
	assign o_pslverr = q.pslverr;
	assign o_warn = q.warn;

endmodule // lqta_top

// ### bench/lqta_checker.sv
// port assertions for the threshold access block
module lqta_checker (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [10:0] o_warn
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	wire logic rd_data = o_pready && !i_pwrite && i_paddr == 12'h078;
	wire logic rd_warn = o_pready && !i_pwrite && i_paddr == 12'h080;
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_one_wait: assert property (i_psel && i_penable && !$past(i_penable)
		|-> !o_pready ##1 o_pready) else $error("ready not after one wait");
	a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready too long");
	a_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
	a_idle_quiet: assert property (!i_penable |=> !o_pready) else $error("ready while idle");
	a_addr_err: assert property (o_pready |-> o_pslverr
		== !(i_paddr inside {12'h078, 12'h080, 12'h084})) else $error("bad error flag");
	a_resv_zero: assert property (rd_data |-> o_prdata[31:14] == 0) else $error("top bits");
	a_strobe_zero: assert property (rd_data |-> !o_prdata[12]) else $error("strobe read");
	a_reset_clean: assert property ($rose(i_rstn) |-> o_prdata == 0 && o_warn == 0)
		else $error("state after reset");
	a_warn_copy: assert property (rd_warn |-> o_prdata == {21'h0, $past(o_warn)})
		else $error("warn read mismatch");
	a_rdata_hold: assert property (!o_pready |-> $stable(o_prdata)) else $error("data moved");
	c_sample_read: cover property (rd_data && o_prdata[13]);
	c_slave_err: cover property (o_pslverr);
	c_warn_set: cover property (o_warn != 0);
endmodule // lqta_checker

bind lqta_top lqta_checker u_chk (.i_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite,
	.i_paddr, .o_prdata, .o_pready, .o_pslverr, .o_warn);

// ### bench/lqta_dsp_model.sv
// live receive parameter source standing in for the dsp
module lqta_dsp_model (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [55:0] i_val,
	output logic [7:0] o_c1,
	output logic [7:0] o_gain,
	output logic [7:0] o_blw,
	output logic [7:0] o_foff,
	output logic [7:0] o_fctl,
	output logic [31:0] o_variance
);
	logic [55:0] val_q;
	logic [15:0] noise_q;
	// low variance half is unused by the monitor, so it never sits still
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			noise_q <= 16'hA5C3;
		else
			noise_q <= {noise_q[14:0], ~noise_q[15]};
	end
	always_ff @(posedge i_clk) begin
		val_q <= i_val;
	end
	assign {o_fctl, o_foff, o_blw, o_gain, o_c1} = val_q[39:0];
	assign o_variance = {val_q[55:40], noise_q};
endmodule // lqta_dsp_model

// ### bench/link_quality_threshold_access_bench.sv
// self-checking bench for the threshold access block
module link_quality_threshold_access_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, psel, penable, pwrite, pslverr, pready, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, variance;
	logic [10:0] warn;
	logic [7:0] c1, gain, blw, foff, fctl, e;
	logic [7:0] thr [12];
	logic [55:0] lv;
	int error_cnt = 0;
	int tests_run = 0;
	lqta_dsp_model u_dsp (.i_clk(clk), .i_rstn(rstn), .i_val(lv), .o_c1(c1), .o_gain(gain),
		.o_blw(blw), .o_foff(foff), .o_fctl(fctl), .o_variance(variance));
	lqta_top DUT (.i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_live_c1(c1),
		.i_live_gain(gain), .i_live_blw(blw), .i_live_foff(foff), .i_live_fctl(fctl),
		.i_variance(variance), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_warn(warn));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] dval(input logic s, input int i, input logic [7:0] x);
		return {18'h0, s, 1'b0, 3'(i >> 1), i[0], x};
	endfunction
	function automatic logic [7:0] live(input int i);
		if (i < 10)
			return lv[(i >> 1) * 8 +: 8];
		return i[0] ? lv[55:48] : lv[47:40];
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no fixed wait count: only the watchdog ends a hung transfer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task summarize;
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// clock, watchdog, tests
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		error_cnt++;
		summarize();
	end
	initial begin
		void'($urandom(94389));
		{rstn, psel, penable, pwrite, paddr, pwdata} = '0;
		lv = {16'h8080, {5{8'h80}}};
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		xfer(1'b0, 12'h078, 0);
		chk(rd, 32'h0000_0080);
		lv[7:0] <= 8'h7F;
		repeat (4) @(posedge clk);
		lv[7:0] <= 8'h80;
		repeat (4) @(posedge clk);
		chk(32'(warn), 32'h1);
		xfer(1'b0, 12'h080, 0);
		chk(rd, 32'h1);
		xfer(1'b0, 12'h080, 0);
		chk(rd, 32'h0);
		for (int i = 0; i < 12; i++) begin
			thr[i] = (i == 0) ? 8'h00 : (i == 11) ? 8'hFF : 8'($urandom);
			xfer(1'b1, 12'h078, dval(1'b0, i, thr[i]) | 32'h0000_1000);
		end
		for (int i = 0; i < 12; i++) begin
			xfer(1'b1, 12'h078, dval(1'b0, i, 8'h00));
			xfer(1'b0, 12'h078, 0);
			chk(rd, dval(1'b0, i, thr[i]));
		end
		lv <= {$urandom, 24'($urandom)};
		repeat (2) @(posedge clk);
		for (int i = 0; i < 12; i++) begin
			xfer(1'b1, 12'h078, dval(1'b1, i, 8'h00));
			xfer(1'b0, 12'h078, 0);
			chk(rd, dval(1'b1, i, live(i)));
		end
		e = live(11);
		lv <= ~lv;
		repeat (3) @(posedge clk);
		xfer(1'b0, 12'h078, 0);
		chk(rd, dval(1'b1, 11, e));
		xfer(1'b1, 12'h084, 32'h1);
		xfer(1'b0, 12'h084, 0);
		chk(rd, 32'h1);
		xfer(1'b1, 12'h078, dval(1'b0, 0, ~thr[0]) | 32'h0000_1000);
		xfer(1'b1, 12'h084, 0);
		xfer(1'b1, 12'h078, 32'hFFFF_C000);
		xfer(1'b0, 12'h078, 0);
		chk(rd, dval(1'b0, 0, thr[0]));
		xfer(1'b0, 12'h07C, 0);
		chk({er, rd[30:0]}, 32'h8000_0000);
		summarize();
	end
endmodule // link_quality_threshold_access_bench
